// [rtl/adc_seq_pkg.sv]
// shared constants and types for the converter sequencing and result block
package adc_seq_pkg;
  // ==========================================================
  // register indices (printed offsets; byte address = 4*index)
  localparam logic [12:0] IDX_FILTER_OUTPUT = 13'h1D14;
  localparam logic [12:0] IDX_TRIGGER_TALLY = 13'h1D19;
  localparam logic [12:0] IDX_CHECK_INTERVAL = 13'h1D1A;
  localparam logic [12:0] IDX_EARLIER_VALUE = 13'h1D1B;
  localparam logic [12:0] IDX_CONV_OUTCOME = 13'h1D1D;
  localparam logic [12:0] IDX_SAMPLING_WINDOW = 13'h1D21;
  localparam logic [12:0] IDX_EXTRA_CHARGE = 13'h1D23;
  localparam logic [12:0] IDX_CHARGE_SETUP = 13'h1D24;
  localparam logic [12:0] IDX_SAMPLING_HIGH = 13'h1D30;
  localparam logic [12:0] IDX_SAMPLING_LOW = 13'h1D31;
  localparam logic [12:0] IDX_CHARGE_HIGH = 13'h1D32;
  localparam logic [12:0] IDX_CHARGE_LOW = 13'h1D33;
  localparam logic [12:0] IDX_CONTROL = 13'h1D34;
  localparam logic [12:0] IDX_STATUS = 13'h1D35;
  localparam logic [12:0] IDX_IRQ_STATUS = 13'h1D36;
  localparam logic [12:0] IDX_IRQ_MASK = 13'h1D37;
  // ==========================================================
  // field positions and reset values
  localparam int CTRL_RC_SEL_BIT = 0;
  localparam int CTRL_PSRC_BIT = 1;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_SHIFT_LSB = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_CHECK_BIT = 1;
  localparam logic [12:0] LEN_RESET = 13'h0000;
  localparam logic [15:0] WORD16_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [4:0] CAP_RESET = 5'h00;
  localparam logic [13:0] ACQ_ZERO_CYCLES = 14'h2000;
  localparam logic [7:0] TALLY_MAX = 8'hFF;
  // ==========================================================
  // computation modes and stage codes
  typedef enum logic [2:0]
  {
    MODE_BASIC = 3'h0,
    MODE_ACCUM = 3'h1,
    MODE_AVG = 3'h2,
    MODE_BURST = 3'h3,
    MODE_LPF = 3'h4
  } calc_mode_t;
  typedef enum logic [2:0]
  {
    STG_IDLE = 3'b000,
    STG_PRE = 3'b001,
    STG_ACQ = 3'b010,
    STG_CONV = 3'b011
  } stage_t;
endpackage

// [rtl/adc_seq.sv]
// conversion sequencing, trigger tally and result registers behind apb
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module adc_seq
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic trigger_in,
  input wire logic dedicated_rc_osc_in,
  input wire logic conv_done_in,
  input wire logic [15:0] sample_in,
  input wire logic [17:0] running_sum_in,
  input wire logic [15:0] low_pass_in,
  output logic [2:0] stage_out,
  output logic [4:0] extra_sample_charge_sel_out,
  output logic check_threshold_out,
  output logic irq_out
);
  // ==========================================================
  // state
  typedef struct packed
  {
    logic [12:0] charge_setup;
    logic [12:0] sampling_window_count;
    logic [4:0] extra_sample_charge_sel;
    logic [7:0] check_interval;
    logic [7:0] trigger_tally;
    logic [15:0] filter_output;
    logic [15:0] earlier_value;
    logic [15:0] conversion_outcome;
    logic rc_sel;
    logic earlier_source_sel;
    logic [2:0] mode;
    logic [3:0] sum_shift_amount;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    adc_seq_pkg::stage_t stage;
    logic [13:0] remain;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic check;
    logic irq;
  } state_t;
  state_t st;
  state_t next_st;
  logic [12:0] idx;
  logic wr_acc;
  logic rd_acc;
  logic tick;
  logic trig_edge;
  logic mapped;
  logic [31:0] rdata;
  logic signed [17:0] shifted;
  assign idx = paddr_in[14:2];
  assign wr_acc = psel_in && penable_in && pwrite_in && !st.pready;
  assign rd_acc = psel_in && penable_in && !pwrite_in && !st.pready;
  assign shifted = $signed(running_sum_in) >>> st.sum_shift_amount;
  // rc edge taken only from synchronised copies, never the first stage
  assign tick = st.rc_sel ? (st.rc_s2 && !st.rc_s3) : 1'b1;
  assign trig_edge = st.trig_s2 && !st.trig_s3;
  // ==========================================================
  // read mux
  always_comb
  begin
    rdata = 32'h00000000;
    mapped = 1'b1;
    unique case (idx)
      adc_seq_pkg::IDX_FILTER_OUTPUT: rdata[15:0] = st.filter_output;
      adc_seq_pkg::IDX_TRIGGER_TALLY: rdata[7:0] = st.trigger_tally;
      adc_seq_pkg::IDX_CHECK_INTERVAL: rdata[7:0] = st.check_interval;
      adc_seq_pkg::IDX_EARLIER_VALUE: rdata[15:0] = st.earlier_value;
      adc_seq_pkg::IDX_CONV_OUTCOME: rdata[15:0] = st.conversion_outcome;
      adc_seq_pkg::IDX_SAMPLING_WINDOW: rdata[12:0] = st.sampling_window_count;
      adc_seq_pkg::IDX_EXTRA_CHARGE: rdata[4:0] = st.extra_sample_charge_sel;
      adc_seq_pkg::IDX_CHARGE_SETUP: rdata[12:0] = st.charge_setup;
      adc_seq_pkg::IDX_SAMPLING_HIGH: rdata[4:0] = st.sampling_window_count[12:8];
      adc_seq_pkg::IDX_SAMPLING_LOW: rdata[7:0] = st.sampling_window_count[7:0];
      adc_seq_pkg::IDX_CHARGE_HIGH: rdata[4:0] = st.charge_setup[12:8];
      adc_seq_pkg::IDX_CHARGE_LOW: rdata[7:0] = st.charge_setup[7:0];
      adc_seq_pkg::IDX_CONTROL: rdata[11:0] = {st.sum_shift_amount, 1'b0, st.mode, 2'b00,
                                              st.earlier_source_sel, st.rc_sel};
      adc_seq_pkg::IDX_STATUS: rdata[2:0] = st.stage;
      adc_seq_pkg::IDX_IRQ_STATUS: rdata[1:0] = st.irq_status;
      adc_seq_pkg::IDX_IRQ_MASK: rdata[1:0] = st.irq_mask;
      default: mapped = 1'b0;
    endcase
  end
  // ==========================================================
  // next state
  always_comb
  begin
    logic [1:0] ev;
    logic avg_mode;
    ev = 2'b00;
    next_st = st;
    avg_mode = (st.mode == adc_seq_pkg::MODE_AVG) || (st.mode == adc_seq_pkg::MODE_BURST) ||
               (st.mode == adc_seq_pkg::MODE_LPF);
    next_st.rc_s1 = dedicated_rc_osc_in;
    next_st.rc_s2 = st.rc_s1;
    next_st.rc_s3 = st.rc_s2;
    next_st.trig_s1 = trigger_in;
    next_st.trig_s2 = st.trig_s1;
    next_st.trig_s3 = st.trig_s2;
    next_st.check = 1'b0;
    // apb: one wait state, answer registered
    next_st.pready = psel_in && penable_in && !st.pready;
    next_st.pslverr = (wr_acc || rd_acc) && !mapped;
    if (rd_acc)
    begin
      next_st.prdata = rdata;
    end
    // filter output tracks the computation every cycle
    if (st.mode == adc_seq_pkg::MODE_LPF)
    begin
      next_st.filter_output = low_pass_in;
    end
    else
    begin
      next_st.filter_output = shifted[15:0];
    end
    // stage sequencer
    unique case (st.stage)
      adc_seq_pkg::STG_IDLE:
      begin
        if (trig_edge)
        begin
          next_st.earlier_value = st.earlier_source_sel ? st.filter_output : st.conversion_outcome;
          if (st.charge_setup != 13'h0000)
          begin
            next_st.stage = adc_seq_pkg::STG_PRE;
            next_st.remain = {1'b0, st.charge_setup};
          end
          else if (st.sampling_window_count != 13'h0000)
          begin
            next_st.stage = adc_seq_pkg::STG_ACQ;
            next_st.remain = {1'b0, st.sampling_window_count};
          end
          else
          begin
            next_st.stage = adc_seq_pkg::STG_CONV;
          end
          if (avg_mode)
          begin
            if (st.trigger_tally != adc_seq_pkg::TALLY_MAX)
            begin
              next_st.trigger_tally = st.trigger_tally + 8'h01;
            end
            if (st.trigger_tally + 8'h01 == st.check_interval)
            begin
              next_st.check = 1'b1;
              ev[adc_seq_pkg::IRQ_CHECK_BIT] = 1'b1;
            end
          end
        end
      end
      adc_seq_pkg::STG_PRE:
      begin
        if (tick)
        begin
          next_st.remain = st.remain - 14'h0001;
          if (st.remain == 14'h0001)
          begin
            next_st.stage = adc_seq_pkg::STG_ACQ;
            next_st.remain = (st.sampling_window_count == 13'h0000) ? adc_seq_pkg::ACQ_ZERO_CYCLES
                             : {1'b0, st.sampling_window_count};
          end
        end
      end
      adc_seq_pkg::STG_ACQ:
      begin
        if (tick)
        begin
          next_st.remain = st.remain - 14'h0001;
          if (st.remain == 14'h0001)
          begin
            next_st.stage = adc_seq_pkg::STG_CONV;
          end
        end
      end
      adc_seq_pkg::STG_CONV:
      begin
        if (conv_done_in)
        begin
          next_st.conversion_outcome = sample_in;
          next_st.stage = adc_seq_pkg::STG_IDLE;
          ev[adc_seq_pkg::IRQ_DONE_BIT] = 1'b1;
        end
      end
      default: next_st.stage = adc_seq_pkg::STG_IDLE;
    endcase
    // register writes take effect in the access cycle
    if (wr_acc && pstrb_in[0])
    begin
      unique case (idx)
        adc_seq_pkg::IDX_TRIGGER_TALLY: next_st.trigger_tally = pwdata_in[7:0];
        adc_seq_pkg::IDX_CHECK_INTERVAL: next_st.check_interval = pwdata_in[7:0];
        adc_seq_pkg::IDX_CONV_OUTCOME: next_st.conversion_outcome[7:0] = pwdata_in[7:0];
        adc_seq_pkg::IDX_SAMPLING_WINDOW: next_st.sampling_window_count[7:0] = pwdata_in[7:0];
        adc_seq_pkg::IDX_EXTRA_CHARGE: next_st.extra_sample_charge_sel = pwdata_in[4:0];
        adc_seq_pkg::IDX_CHARGE_SETUP: next_st.charge_setup[7:0] = pwdata_in[7:0];
        adc_seq_pkg::IDX_SAMPLING_HIGH: next_st.sampling_window_count[12:8] = pwdata_in[4:0];
        adc_seq_pkg::IDX_SAMPLING_LOW: next_st.sampling_window_count[7:0] = pwdata_in[7:0];
        adc_seq_pkg::IDX_CHARGE_HIGH: next_st.charge_setup[12:8] = pwdata_in[4:0];
        adc_seq_pkg::IDX_CHARGE_LOW: next_st.charge_setup[7:0] = pwdata_in[7:0];
        adc_seq_pkg::IDX_CONTROL:
        begin
          next_st.rc_sel = pwdata_in[adc_seq_pkg::CTRL_RC_SEL_BIT];
          next_st.earlier_source_sel = pwdata_in[adc_seq_pkg::CTRL_PSRC_BIT];
          next_st.mode = pwdata_in[adc_seq_pkg::CTRL_MODE_LSB +: 3];
        end
        adc_seq_pkg::IDX_IRQ_MASK: next_st.irq_mask = pwdata_in[1:0];
        default: next_st.pslverr = next_st.pslverr;
      endcase
    end
    if (wr_acc && pstrb_in[1])
    begin
      unique case (idx)
        adc_seq_pkg::IDX_CONV_OUTCOME: next_st.conversion_outcome[15:8] = pwdata_in[15:8];
        adc_seq_pkg::IDX_SAMPLING_WINDOW: next_st.sampling_window_count[12:8] = pwdata_in[12:8];
        adc_seq_pkg::IDX_CHARGE_SETUP: next_st.charge_setup[12:8] = pwdata_in[12:8];
        adc_seq_pkg::IDX_CONTROL: next_st.sum_shift_amount = pwdata_in[adc_seq_pkg::CTRL_SHIFT_LSB +: 4];
        default: next_st.pslverr = next_st.pslverr;
      endcase
    end
    // write-one-to-clear, but a new event wins over the clear
    if (wr_acc && pstrb_in[0] && idx == adc_seq_pkg::IDX_IRQ_STATUS)
    begin
      next_st.irq_status = st.irq_status & ~pwdata_in[1:0];
    end
    next_st.irq_status = next_st.irq_status | ev;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end
  // ==========================================================
  // state register; reset clears all but filter output, which still loads the computed value
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st <= '0;
      st.filter_output <= next_st.filter_output;
    end
    else
    begin
      st <= next_st;
    end
  end
  assign prdata_out = st.prdata;
  assign pready_out = st.pready;
  assign pslverr_out = st.pslverr;
  assign stage_out = st.stage;
  assign extra_sample_charge_sel_out = st.extra_sample_charge_sel;
  assign check_threshold_out = st.check;
  assign irq_out = st.irq;
  // ==========================================================
  // assertions
  property p_pre_len;
    @(posedge sys_clk_in) disable iff (rst_in)
    (st.stage == adc_seq_pkg::STG_IDLE && next_st.stage == adc_seq_pkg::STG_PRE && !st.rc_sel &&
     st.charge_setup == 13'h0002) |=> (st.stage == adc_seq_pkg::STG_PRE) [*2] ##1 (st.stage != adc_seq_pkg::STG_PRE);
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("precharge length wrong");
  property p_pre_skip;
    @(posedge sys_clk_in) disable iff (rst_in)
    (st.stage == adc_seq_pkg::STG_IDLE && trig_edge && st.charge_setup == 13'h0000) |=>
      st.stage != adc_seq_pkg::STG_PRE;
  endproperty
  a_pre_skip: assert property (p_pre_skip) else $error("precharge not skipped");
  property p_acq_len;
    @(posedge sys_clk_in) disable iff (rst_in)
    ($rose(st.stage == adc_seq_pkg::STG_ACQ) && !st.rc_sel && st.remain == 14'h0003) |->
      ##1 (st.stage == adc_seq_pkg::STG_ACQ) [*2] ##1 (st.stage == adc_seq_pkg::STG_CONV);
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition length wrong");
  property p_acq_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
    (st.stage == adc_seq_pkg::STG_PRE && next_st.stage == adc_seq_pkg::STG_ACQ &&
     st.sampling_window_count == 13'h0000) |=> st.remain == adc_seq_pkg::ACQ_ZERO_CYCLES;
  endproperty
  a_acq_zero: assert property (p_acq_zero) else $error("acquisition zero not 8192");
  property p_rc_hold;
    @(posedge sys_clk_in) disable iff (rst_in)
    (st.rc_sel && !tick && st.stage == adc_seq_pkg::STG_PRE) |=> $stable(st.remain);
  endproperty
  a_rc_hold: assert property (p_rc_hold) else $error("counted without rc tick");
  property p_tally_sat;
    @(posedge sys_clk_in) disable iff (rst_in)
    (st.trigger_tally == adc_seq_pkg::TALLY_MAX && !wr_acc) |=> st.trigger_tally == adc_seq_pkg::TALLY_MAX;
  endproperty
  a_tally_sat: assert property (p_tally_sat) else $error("tally wrapped");
  property p_prev;
    @(posedge sys_clk_in) disable iff (rst_in)
    (st.stage == adc_seq_pkg::STG_IDLE && trig_edge && !st.earlier_source_sel) |=>
      st.earlier_value == $past(st.conversion_outcome);
  endproperty
  a_prev: assert property (p_prev) else $error("earlier value not captured");
  property p_result;
    @(posedge sys_clk_in) disable iff (rst_in)
    (st.stage == adc_seq_pkg::STG_CONV && conv_done_in) |=> st.conversion_outcome == $past(sample_in);
  endproperty
  a_result: assert property (p_result) else $error("result not stored");
  property p_lpf;
    @(posedge sys_clk_in) disable iff (rst_in)
    (st.mode == adc_seq_pkg::MODE_LPF) |=> st.filter_output == $past(low_pass_in);
  endproperty
  a_lpf: assert property (p_lpf) else $error("filter output not low-pass");
  c_pre: cover property (@(posedge sys_clk_in) st.stage == adc_seq_pkg::STG_PRE);
  c_conv_done: cover property (@(posedge sys_clk_in) st.stage == adc_seq_pkg::STG_CONV && conv_done_in);
  c_check: cover property (@(posedge sys_clk_in) st.check);
endmodule

// [dv/test_adc_seq.sv]
// self-checking bench for the converter sequencing and result block
`timescale 1ns/1ps
module test_adc_seq;
  logic sys_clk_in, rst_in, psel_in, penable_in, pwrite_in, trigger_in, dedicated_rc_osc_in, conv_done_in;
  logic [31:0] paddr_in = 32'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'hF;
  logic [15:0] sample_in, low_pass_in;
  logic [17:0] running_sum_in;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, check_threshold_out, irq_out;
  logic [2:0] stage_out;
  logic [4:0] extra_sample_charge_sel_out;
  int n_fail = 0;
  int checks = 0;
  int n_check = 0;
  int run_len = 0;
  int len [4];
  logic [2:0] last_stage = 3'h0;
  logic [2:0] rc_div = 3'h0;
  logic [31:0] d;
  logic e;
  int pre_t [4] = '{2, 0, 0, 8191};
  int acq_t [4] = '{1, 3, 0, 0};
  int acq_x [4] = '{1, 3, 0, 8192};

  adc_seq adc_seq_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .trigger_in(trigger_in),
    .dedicated_rc_osc_in(dedicated_rc_osc_in), .conv_done_in(conv_done_in), .sample_in(sample_in),
    .running_sum_in(running_sum_in), .low_pass_in(low_pass_in), .stage_out(stage_out),
    .extra_sample_charge_sel_out(extra_sample_charge_sel_out), .check_threshold_out(check_threshold_out),
    .irq_out(irq_out));

  // ==========================================================
  // clock, rc tick source and stage length monitor
  initial
  begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // rc ticks every 8 system cycles so rc counts are clearly longer
  always @(posedge sys_clk_in)
  begin
    rc_div <= rc_div + 3'h1;
    dedicated_rc_osc_in <= rc_div[2];
  end

  // length of each stage recorded when the stage ends
  always @(posedge sys_clk_in)
  begin
    if (check_threshold_out === 1'b1)
      n_check++;
    if (stage_out === last_stage)
      run_len++;
    else
    begin
      len[last_stage[1:0]] = run_len;
      run_len = 1;
    end
    last_stage = stage_out;
  end

  // ==========================================================
  // access tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [12:0] idx, input logic [31:0] wd);
    int n;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= {17'h0, idx, 2'h0};
    pwdata_in <= wd;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 50);
    d = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 50)
      n_fail++;
  endtask

  task automatic rdc(input string what, input logic [12:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(what, d, exp);
  endtask

  function automatic logic [31:0] ctl(input int rc, input int ps, input int md, input int sh);
    return (32'(rc) << adc_seq_pkg::CTRL_RC_SEL_BIT) | (32'(ps) << adc_seq_pkg::CTRL_PSRC_BIT)
      | (32'(md) << adc_seq_pkg::CTRL_MODE_LSB) | (32'(sh) << adc_seq_pkg::CTRL_SHIFT_LSB);
  endfunction

  // one trigger, wait for the conversion stage, then finish at once with a sample
  task automatic conv(input logic [15:0] smp);
    int n;
    len = '{default: 0};
    trigger_in <= 1'b1;
    n = 0;
    while (stage_out !== 3'h3 && n < 20000)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    trigger_in <= 1'b0;
    sample_in <= smp;
    conv_done_in <= 1'b1;
    @(posedge sys_clk_in);
    conv_done_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    if (n >= 20000)
      n_fail++;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // sequence lengths are bounded well below this span
  initial
  begin
    repeat (40000) @(posedge sys_clk_in);
    n_fail++;
    results();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {rst_in, psel_in, penable_in, pwrite_in, trigger_in, conv_done_in} = 6'h20;
    {sample_in, low_pass_in, running_sum_in} = '0;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rdc("tally reset", adc_seq_pkg::IDX_TRIGGER_TALLY, 0);
    rdc("interval reset", adc_seq_pkg::IDX_CHECK_INTERVAL, 0);
    rdc("earlier reset", adc_seq_pkg::IDX_EARLIER_VALUE, 0);
    rdc("outcome reset", adc_seq_pkg::IDX_CONV_OUTCOME, 0);
    rdc("window reset", adc_seq_pkg::IDX_SAMPLING_WINDOW, 0);
    rdc("setup reset", adc_seq_pkg::IDX_CHARGE_SETUP, 0);
    chk("stage idle", stage_out, 0);
    rdc("unmapped data", 13'h1D00, 0);
    chk("unmapped err", e, 1);
    // byte halves and the 13-bit word views
    apb(1'b1, adc_seq_pkg::IDX_CHARGE_HIGH, 32'hFF);
    apb(1'b1, adc_seq_pkg::IDX_CHARGE_LOW, 32'h02);
    rdc("setup word", adc_seq_pkg::IDX_CHARGE_SETUP, 32'h1F02);
    apb(1'b1, adc_seq_pkg::IDX_SAMPLING_WINDOW, 32'hFFFF_1234);
    rdc("window high", adc_seq_pkg::IDX_SAMPLING_HIGH, 32'h12);
    rdc("window low", adc_seq_pkg::IDX_SAMPLING_LOW, 32'h34);
    // stage lengths on the system clock, zero and maximum counts included
    apb(1'b1, adc_seq_pkg::IDX_IRQ_MASK, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, adc_seq_pkg::IDX_CHARGE_SETUP, pre_t[i]);
      apb(1'b1, adc_seq_pkg::IDX_SAMPLING_WINDOW, acq_t[i]);
      conv(16'h0100 + 16'(i));
      chk("precharge len", len[1], pre_t[i]);
      chk("acquire len", len[2], acq_x[i]);
      rdc("outcome", adc_seq_pkg::IDX_CONV_OUTCOME, 32'h0100 + i);
    end
    // done interrupt: raised, cleared, then masked
    chk("irq raised", irq_out, 1);
    apb(1'b1, adc_seq_pkg::IDX_IRQ_STATUS, 32'h1);
    @(posedge sys_clk_in);
    chk("irq cleared", irq_out, 0);
    apb(1'b1, adc_seq_pkg::IDX_IRQ_MASK, 32'h0);
    apb(1'b1, adc_seq_pkg::IDX_CHARGE_SETUP, 32'h2);
    apb(1'b1, adc_seq_pkg::IDX_SAMPLING_WINDOW, 32'h3);
    apb(1'b1, adc_seq_pkg::IDX_CONTROL, ctl(1, 0, 0, 0));
    conv(16'h0);
    chk("irq masked", irq_out, 0);
    rdc("irq status", adc_seq_pkg::IDX_IRQ_STATUS, 32'h1);
    // rc ticks: 2 and 3 counts of an 8-cycle tick, allowing sync skew
    chk("rc precharge", len[1] > 7 && len[1] < 18, 1);
    chk("rc acquire", len[2] > 15 && len[2] < 26, 1);
    apb(1'b1, adc_seq_pkg::IDX_CHARGE_SETUP, 32'h0);
    apb(1'b1, adc_seq_pkg::IDX_SAMPLING_WINDOW, 32'h0);
    apb(1'b1, adc_seq_pkg::IDX_EXTRA_CHARGE, 32'h15);
    @(posedge sys_clk_in);
    chk("cap select", extra_sample_charge_sel_out, 5'h15);
    // tally and check in every mode; only averaging, burst and filter modes count
    for (int m = 0; m < 5; m++)
    begin
      apb(1'b1, adc_seq_pkg::IDX_CONTROL, ctl(0, 0, m, 0));
      apb(1'b1, adc_seq_pkg::IDX_TRIGGER_TALLY, 32'h0);
      apb(1'b1, adc_seq_pkg::IDX_CHECK_INTERVAL, 32'h1);
      n_check = 0;
      conv(16'h0);
      rdc("tally per mode", adc_seq_pkg::IDX_TRIGGER_TALLY, m >= 2);
      chk("check per mode", n_check, m >= 2);
    end
    apb(1'b1, adc_seq_pkg::IDX_CONTROL, ctl(0, 0, 2, 0));
    apb(1'b1, adc_seq_pkg::IDX_TRIGGER_TALLY, 32'h0);
    apb(1'b1, adc_seq_pkg::IDX_CHECK_INTERVAL, 32'h3);
    apb(1'b1, adc_seq_pkg::IDX_IRQ_STATUS, 32'h3);
    n_check = 0;
    conv(16'h0);
    conv(16'h0);
    chk("check early", n_check, 0);
    rdc("check irq early", adc_seq_pkg::IDX_IRQ_STATUS, 32'h1);
    conv(16'h0);
    chk("check at interval", n_check, 1);
    rdc("check irq set", adc_seq_pkg::IDX_IRQ_STATUS, 32'h3);
    apb(1'b1, adc_seq_pkg::IDX_TRIGGER_TALLY, 32'hFE);
    conv(16'h0);
    conv(16'h0);
    rdc("tally saturates", adc_seq_pkg::IDX_TRIGGER_TALLY, 32'hFF);
    // filter view: shifted sum in three modes, low-pass value in filter mode
    running_sum_in <= 18'h20008;
    low_pass_in <= 16'h8765;
    for (int m = 1; m < 4; m++)
    begin
      apb(1'b1, adc_seq_pkg::IDX_CONTROL, ctl(0, 0, m, 3));
      rdc("shifted sum", adc_seq_pkg::IDX_FILTER_OUTPUT, 32'hC001);
    end
    apb(1'b1, adc_seq_pkg::IDX_CONTROL, ctl(0, 0, 4, 0));
    apb(1'b1, adc_seq_pkg::IDX_FILTER_OUTPUT, 32'h0);
    rdc("low pass view", adc_seq_pkg::IDX_FILTER_OUTPUT, 32'h8765);
    // earlier value follows the selected source at conversion start
    apb(1'b1, adc_seq_pkg::IDX_CONTROL, ctl(0, 0, 0, 0));
    apb(1'b1, adc_seq_pkg::IDX_CONV_OUTCOME, 32'hABCD);
    rdc("outcome written", adc_seq_pkg::IDX_CONV_OUTCOME, 32'hABCD);
    conv(16'h0111);
    rdc("earlier outcome", adc_seq_pkg::IDX_EARLIER_VALUE, 32'hABCD);
    apb(1'b1, adc_seq_pkg::IDX_CONTROL, ctl(0, 1, 4, 0));
    conv(16'h0222);
    apb(1'b1, adc_seq_pkg::IDX_EARLIER_VALUE, 32'h0);
    rdc("earlier filter", adc_seq_pkg::IDX_EARLIER_VALUE, 32'h8765);
    results();
  end
endmodule
